// file: hw/asc_consts.vh
// asc_consts.vh: offsets, field positions, reset values and timing counts
// of the converter sequence and clock control block.
// assumes: included by bare name from the design files of this block.
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ASC_OFF_SEQ_DBG     8'h00
`define ASC_OFF_RES_TIM     8'h04
`define ASC_OFF_START       8'h08
`define ASC_OFF_STATUS      8'h0c
`define ASC_OFF_VALID       8'h10

// ****************************************
// sequence_and_debug_control fields
// ****************************************
`define ASC_SD_HALT_LO      0
`define ASC_SD_HALT_HI      1
`define ASC_SD_RING         2
`define ASC_SD_SINGLE       3
`define ASC_SD_MASK         8'h0f
`define ASC_SD_RESET        8'h00

// ****************************************
// resolution_timing_prescale fields
// ****************************************
`define ASC_RT_PRS_LSB      0
`define ASC_RT_SMP_LSB      5
`define ASC_RT_RES          7
`define ASC_RT_RESET        8'h01

// ****************************************
// sequence_start_control fields
// ****************************************
`define ASC_SS_EIGHT        6
`define ASC_SS_SCAN         5
`define ASC_SS_MASK         8'h7f
`define ASC_SS_RESET        8'h00

// ****************************************
// sequencer timing, in converter clock periods
// ****************************************
`define ASC_PH1_CYC         4'h2
`define ASC_PH2_CYC         4'h4
`define ASC_BITS_LO         4'h8
`define ASC_BITS_HI         4'ha

// ****************************************
// bus responses
// ****************************************
`define ASC_RESP_OKAY       2'b00
`define ASC_RESP_SLVERR     2'b10

`endif

// file: hw/asc_prescaler.v
// asc_prescaler.v: modulus prescaler plus divide-by-two stage.
// assumes: runs on sys_clk; emits one-cycle enable pulses, no derived clock.
`timescale 1ns/10ps
`default_nettype none

module asc_prescaler #(
	parameter W = 5
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         rstn,
	// control
	input  wire [W-1:0] prs,
	input  wire         restart,
	// converter clock enable
	output reg          tick
);
	reg [W-1:0] cnt_r;
	reg         half_r;

	always @(posedge sys_clk) begin
		if (!rstn || restart) begin
			cnt_r  <= {W{1'b0}};
			half_r <= 1'b0;
			tick   <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (cnt_r >= prs) begin
				cnt_r  <= {W{1'b0}};
				half_r <= ~half_r;
				tick   <= half_r;
			end else begin
				cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

`default_nettype wire

// file: hw/asc_valid_flags.v
// asc_valid_flags.v: one conversion-complete flag per result register.
// assumes: write strobes come from the sequencer on sys_clk.
`timescale 1ns/10ps
`default_nettype none

module asc_valid_flags #(
	parameter N  = 8,
	parameter AW = 3
) (
	// clock and reset
	input  wire          sys_clk,
	input  wire          rstn,
	// control
	input  wire          clr_all,
	input  wire          wr,
	input  wire [AW-1:0] wr_idx,
	// flags
	output reg  [N-1:0]  flags
);
	integer i;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			flags <= {N{1'b0}};
		end else begin
			for (i = 0; i < N; i = i + 1) begin
				// a write in the clearing cycle still marks its register
				if (wr && wr_idx == i[AW-1:0])
					flags[i] <= 1'b1;
				else if (clr_all)
					flags[i] <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// file: hw/asc_top.v
// asc_top.v: converter sequence, debug freeze and clock control, AXI4-Lite slave.
// assumes: single sys_clk domain; analog side is driven through the adc_* outputs;
// debug_halt comes from the processor debug logic on the same clock.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "asc_consts.vh"

// Operation
// - halt bits 00: conversions keep running during debug mode
// - halt bits 10: finish current conversion, then pause in debug mode
// - halt bits 11: pause at once while debug mode is active
// - leaving debug mode resumes exactly where the sequencer stopped
// - timing register writes take effect at once
// - timing register write aborts the whole running sequence
// - write to timing or start register begins a fresh sequence
// - resolution bit clear gives 8 bits, set gives 10 bits
// - 8-bit mode uses fewer conversion periods than 10-bit mode
// - final sample phase lasts 2, 4, 8 or 16 converter periods
// - final sample phase follows buffered sample and transfer, input direct
// - prescale field plus one is the bus clock divide modulus
// - prescaler output is halved again to form the converter clock
// - prescale field resets to 00001, quarter of bus clock
// - one conversion-complete flag per result register
// - length 4 by default, 1 with single bit, 8 with eight bit
// - normal: nth result to nth register; ring mode continues and wraps
module asc_top #(
	parameter NREG = 8
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// axi4-lite write
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// debug
	input  wire        debug_halt,
	// analog side
	output reg         adc_tick,
	output reg         adc_sample_buf,
	output reg         adc_sample_direct,
	output reg         adc_convert,
	output reg         adc_resolution_select,
	output reg         result_wr,
	output reg  [2:0]  result_idx,
	output reg  [7:0]  valid_flags,
	output reg         seq_busy,
	output reg         seq_done
);
	// ****************************************
	// state
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_PH1  = 3'd1;
	localparam ST_PH2  = 3'd2;
	localparam ST_PH3  = 3'd3;
	localparam ST_CONV = 3'd4;

	reg [7:0]  seq_dbg_r;
	reg [7:0]  res_tim_r;
	reg [7:0]  start_r;
	reg [2:0]  st_r;
	reg [4:0]  pcnt_r;
	reg [3:0]  ncnt_r;
	reg [2:0]  ptr_r;
	reg        froz_r;
	reg [7:0]  aw_addr_r;
	reg        aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	reg        w_have_r;
	reg        restart_r;

	wire       tick;
	wire [7:0] flags;

	// ****************************************
	// decoded fields
	// ****************************************
	wire       halt_hi = seq_dbg_r[`ASC_SD_HALT_HI];
	wire       halt_lo = seq_dbg_r[`ASC_SD_HALT_LO];
	wire       ring    = seq_dbg_r[`ASC_SD_RING];
	wire [1:0] smp     = res_tim_r[`ASC_RT_SMP_LSB+1:`ASC_RT_SMP_LSB];
	wire       resolution_select   = res_tim_r[`ASC_RT_RES];
	wire       scan    = start_r[`ASC_SS_SCAN];

	wire [3:0] seq_len = start_r[`ASC_SS_EIGHT] ? 4'h8 :
		(seq_dbg_r[`ASC_SD_SINGLE] ? 4'h1 : 4'h4);
	wire [4:0] ph3_len = 5'h02 << smp;
	wire [4:0] conv_len = {1'b0, resolution_select ? `ASC_BITS_HI : `ASC_BITS_LO};

	// ****************************************
	// bus write
	// ****************************************
	wire do_wr  = aw_have_r && w_have_r && !s_axi_bvalid;
	wire wr_sd  = do_wr && aw_addr_r == `ASC_OFF_SEQ_DBG;
	wire wr_rt  = do_wr && aw_addr_r == `ASC_OFF_RES_TIM;
	wire wr_ss  = do_wr && aw_addr_r == `ASC_OFF_START;
	wire wr_ok  = wr_sd || wr_rt || wr_ss ||
		(do_wr && (aw_addr_r == `ASC_OFF_STATUS || aw_addr_r == `ASC_OFF_VALID));
	wire kick   = (wr_rt || wr_ss) && w_strb_r[0];

	always @(posedge sys_clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ASC_RESP_OKAY;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			seq_dbg_r     <= `ASC_SD_RESET;
			res_tim_r     <= `ASC_RT_RESET;
			start_r       <= `ASC_SS_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r     <= {s_axi_awaddr[7:2], 2'b00};
				aw_have_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				w_have_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				if (w_strb_r[0]) begin
					if (wr_sd)
						seq_dbg_r <= w_data_r[7:0] & `ASC_SD_MASK;
					if (wr_rt)
						res_tim_r <= w_data_r[7:0];
					if (wr_ss)
						start_r <= w_data_r[7:0] & `ASC_SS_MASK;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ****************************************
	// bus read
	// ****************************************
	reg [31:0] rd_mux;
	reg        rd_hit;
	always @* begin
		rd_hit = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`ASC_OFF_SEQ_DBG: rd_mux = {24'h000000, seq_dbg_r};
			`ASC_OFF_RES_TIM: rd_mux = {24'h000000, res_tim_r};
			`ASC_OFF_START:   rd_mux = {24'h000000, start_r};
			`ASC_OFF_STATUS:  rd_mux = {20'h00000, froz_r, ptr_r, ncnt_r, 1'b0, st_r};
			`ASC_OFF_VALID:   rd_mux = {24'h000000, flags};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ASC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// converter clock
	// ****************************************
	// restart keeps a fresh sequence aligned to the new divide ratio
	always @(posedge sys_clk) begin
		if (!rstn)
			restart_r <= 1'b0;
		else
			restart_r <= wr_rt;
	end

	asc_prescaler #(.W(5)) u_prs (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.prs     (res_tim_r[`ASC_RT_PRS_LSB+4:`ASC_RT_PRS_LSB]),
		.restart (restart_r),
		.tick    (tick)
	);

	// ****************************************
	// debug freeze
	// ****************************************
	// 01 is treated like 00; its effect is left open to software
	wire at_conv_end = st_r == ST_CONV && pcnt_r == 5'h01;
	// code 10 lets the conversion-ending tick through, then holds
	wire soft_mode   = debug_halt && halt_hi && !halt_lo;
	wire freeze_now  = debug_halt && halt_hi && halt_lo;
	wire freeze_soft = soft_mode && (froz_r || st_r == ST_IDLE);
	wire frozen      = freeze_now || freeze_soft;
	wire step        = tick && !frozen && st_r != ST_IDLE;

	always @(posedge sys_clk) begin
		if (!rstn)
			froz_r <= 1'b0;
		else
			froz_r <= debug_halt && (frozen || (soft_mode && at_conv_end && step));
	end

	// ****************************************
	// sequencer
	// ****************************************
	wire last = ncnt_r == seq_len - 4'h1;
	wire [2:0] ptr_inc = (ptr_r == NREG - 1) ? 3'd0 : ptr_r + 3'd1;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			st_r      <= ST_IDLE;
			pcnt_r    <= 5'h00;
			ncnt_r    <= 4'h0;
			ptr_r     <= 3'd0;
			result_idx <= 3'd0;
			result_wr <= 1'b0;
			seq_done  <= 1'b0;
		end else begin
			result_wr <= 1'b0;
			seq_done  <= 1'b0;
			if (kick) begin
				st_r   <= ST_PH1;
				pcnt_r <= {1'b0, `ASC_PH1_CYC};
				ncnt_r <= 4'h0;
				if (!ring)
					ptr_r <= 3'd0;
			end else if (step) begin
				if (pcnt_r > 5'h01) begin
					pcnt_r <= pcnt_r - 5'h01;
				end else begin
					case (st_r)
						ST_PH1: begin
							st_r   <= ST_PH2;
							pcnt_r <= {1'b0, `ASC_PH2_CYC};
						end
						ST_PH2: begin
							st_r   <= ST_PH3;
							pcnt_r <= ph3_len;
						end
						ST_PH3: begin
							st_r   <= ST_CONV;
							pcnt_r <= conv_len;
						end
						ST_CONV: begin
							result_wr  <= 1'b1;
							result_idx <= ptr_r;
							ptr_r      <= ptr_inc;
							if (last) begin
								seq_done <= 1'b1;
								ncnt_r   <= 4'h0;
								if (!ring)
									ptr_r <= 3'd0;
								st_r   <= scan ? ST_PH1 : ST_IDLE;
								pcnt_r <= {1'b0, `ASC_PH1_CYC};
							end else begin
								ncnt_r <= ncnt_r + 4'h1;
								st_r   <= ST_PH1;
								pcnt_r <= {1'b0, `ASC_PH1_CYC};
							end
						end
						default: st_r <= ST_IDLE;
					endcase
				end
			end
		end
	end

	asc_valid_flags #(.N(8), .AW(3)) u_flags (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.clr_all (kick),
		.wr      (result_wr),
		.wr_idx  (result_idx),
		.flags   (flags)
	);

	// ****************************************
	// registered analog controls
	// ****************************************
	always @(posedge sys_clk) begin
		if (!rstn) begin
			adc_tick          <= 1'b0;
			adc_sample_buf    <= 1'b0;
			adc_sample_direct <= 1'b0;
			adc_convert       <= 1'b0;
			adc_resolution_select         <= 1'b0;
			seq_busy          <= 1'b0;
			valid_flags       <= 8'h00;
		end else begin
			adc_tick          <= step;
			adc_sample_buf    <= st_r == ST_PH1 || st_r == ST_PH2;
			adc_sample_direct <= st_r == ST_PH3;
			adc_convert       <= st_r == ST_CONV;
			adc_resolution_select         <= resolution_select;
			seq_busy          <= st_r != ST_IDLE;
			valid_flags       <= flags;
		end
	end
endmodule

`default_nettype wire

// file: verif/asc_top_props.sv
// asc_top_props.sv: concurrent checks on the ports of asc_top.
// assumes: bound to asc_top below; single sys_clk domain, rstn sync low.
`timescale 1ns/10ps
`default_nettype none
`include "asc_consts.vh"

module asc_top_props (
	// clock and reset
	input wire        sys_clk,
	input wire        rstn,
	// bus
	input wire [7:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// analog side
	input wire        adc_tick,
	input wire        adc_sample_buf,
	input wire        adc_sample_direct,
	input wire        adc_convert,
	input wire        result_wr,
	input wire [2:0]  result_idx,
	input wire [7:0]  valid_flags
);
	// ****************************************
	// helpers
	// ****************************************
	logic [2:0] idx_r;
	wire        wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	// last written result register, so the flag can be traced to it
	always_ff @(posedge sys_clk) begin
		if (result_wr)
			idx_r <= result_idx;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ****************************************
	// assertions
	// ****************************************
	wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	bad_addr_a: assert property (wr_take && s_axi_awaddr[7:2] > 6'h04
		|-> ##2 s_axi_bresp == `ASC_RESP_SLVERR) else $error("unmapped write not refused");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	tick_gap_a: assert property (adc_tick |=> !adc_tick)
		else $error("converter tick faster than half bus clock");
	phase_excl_a: assert property (adc_convert |-> !adc_sample_buf && !adc_sample_direct)
		else $error("conversion overlaps sampling");
	direct_order_a: assert property ($rose(adc_sample_direct) |-> $past(adc_sample_buf))
		else $error("direct sample not after buffered phase");
	result_src_a: assert property (result_wr |-> $past(adc_convert))
		else $error("result without conversion");
	flag_set_a: assert property (result_wr |-> ##[1:2] valid_flags[idx_r])
		else $error("complete flag not set");
endmodule

bind asc_top asc_top_props u_props (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .adc_tick,
	.adc_sample_buf, .adc_sample_direct, .adc_convert, .result_wr, .result_idx,
	.valid_flags);
`default_nettype wire

// file: verif/tb_adc_sequence_clock_control.sv
// tb_adc_sequence_clock_control.sv: register, sequencer and freeze tests of asc_top.
// assumes: design and checker compiled first; one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "asc_consts.vh"

module tb_adc_sequence_clock_control;
	logic        sys_clk = 1'b0, rstn = 1'b0, debug_halt = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         adc_tick, adc_sample_buf, adc_sample_direct, adc_convert, adc_resolution_select;
	wire         result_wr, seq_busy, seq_done;
	wire  [2:0]  result_idx;
	wire  [7:0]  valid_flags;
	int          error_cnt = 0, n_compared = 0;
	int          tick_cnt, res_cnt, dir_cnt, cnv_cnt, k, i, t0, r0;
	logic [2:0]  exp_idx;
	logic [1:0]  resp;
	logic [31:0] rd;
	logic [7:0]  c3 [4] = '{8'h00, 8'h08, 8'h00, 8'h08};
	logic [7:0]  c5 [4] = '{8'h00, 8'h40, 8'h40, 8'h00};
	int          nn [4] = '{4, 8, 8, 1};
	logic [7:0]  cf [4] = '{8'h06, 8'h27, 8'h46, 8'he7};
	logic [7:0]  hb [3] = '{8'h00, 8'h02, 8'h03};
	int          et [3] = '{12, 0, 0};
	int          er [3] = '{2, 1, 0};

	always #20 sys_clk = ~sys_clk;

	asc_top dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .debug_halt,
		.adc_tick, .adc_sample_buf, .adc_sample_direct, .adc_convert, .adc_resolution_select,
		.result_wr, .result_idx, .valid_flags, .seq_busy, .seq_done);

	// ****************************************
	// monitor and tasks
	// ****************************************
	always @(posedge sys_clk) begin
		if (adc_tick === 1'b1)
			tick_cnt++;
		if (adc_sample_direct === 1'b1)
			dir_cnt++;
		if (adc_convert === 1'b1)
			cnv_cnt++;
		if (result_wr === 1'b1) begin
			cmp("result_idx", exp_idx, result_idx);
			exp_idx++;
			res_cnt++;
		end
	end

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task finish_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task timeout;
		cmp("timeout", 32'h1, 32'h0);
		finish_test;
	endtask

	// master holds each valid until its own ready edge
	task automatic axi_wr(input [7:0] a, input [7:0] d, output [1:0] r);
		int j;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (j == 50)
			timeout;
	endtask

	task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
		int j;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (j == 50)
			timeout;
	endtask

	// counters cleared off the sampling edge to keep clear of the monitor
	task automatic clr(input bit keep);
		@(negedge sys_clk);
		tick_cnt = 0;
		res_cnt = 0;
		dir_cnt = 0;
		cnv_cnt = 0;
		if (!keep)
			exp_idx = 3'h0;
	endtask

	task automatic wait_done;
		int j;
		for (j = 0; j < 4000; j++) begin
			@(posedge sys_clk);
			if (seq_done === 1'b1)
				break;
		end
		// let the last result and its flag land before anyone looks
		if (j == 4000)
			timeout;
		else
			repeat (2) @(negedge sys_clk);
	endtask

	task automatic run_seq(input [7:0] a, input [7:0] d, input int n, input [7:0] fl,
		input bit keep);
		clr(keep);
		axi_wr(a, d, resp);
		wait_done;
		cmp("results", n, res_cnt);
		cmp("valid_flags", fl, valid_flags);
		cmp("seq_busy", 1'b0, seq_busy);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		exp_idx = 3'h0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		axi_rd(8'h00, rd, resp);
		cmp("seq_dbg", 32'h0, rd);
		axi_rd(8'h04, rd, resp);
		cmp("res_tim", 32'h01, rd);
		axi_rd(8'h14, rd, resp);
		cmp("rresp", `ASC_RESP_SLVERR, resp);
		cmp("rdata", 32'h0, rd);
		axi_wr(8'h14, 8'hff, resp);
		cmp("bresp", `ASC_RESP_SLVERR, resp);
		// converter clock kept within its legal band for a 25 MHz bus
		run_seq(8'h04, 8'h06, 4, 8'h0f, 1'b0);
		for (k = 0; k < 4; k++) begin
			axi_wr(8'h00, c3[k], resp);
			run_seq(8'h08, c5[k], nn[k], 8'((1 << nn[k]) - 1), 1'b0);
		end
		for (k = 0; k < 4; k++) begin
			run_seq(8'h04, cf[k], 1, 8'h01, 1'b0);
			cmp("direct", (2 << cf[k][6:5]) * 2 * (cf[k][4:0] + 1), dir_cnt);
			cmp("convert", (cf[k][7] ? 10 : 8) * 2 * (cf[k][4:0] + 1), cnv_cnt);
			cmp("resolution_select", cf[k][7], adc_resolution_select);
			axi_rd(8'h04, rd, resp);
			cmp("res_tim", cf[k], rd);
		end
		// abort an eight-long run after three results
		clr(1'b0);
		axi_wr(8'h08, 8'h40, resp);
		for (i = 0; i < 2000 && res_cnt < 3; i++)
			@(posedge sys_clk);
		if (i == 2000)
			timeout;
		run_seq(8'h04, 8'h07, 8, 8'hff, 1'b0);
		// scan restarts by itself; the start write below stops it
		clr(1'b0);
		axi_wr(8'h08, 8'h20, resp);
		wait_done;
		clr(1'b0);
		wait_done;
		cmp("scan_results", 1, res_cnt);
		cmp("scan_busy", 1, seq_busy);
		run_seq(8'h08, 8'h00, 1, 8'h01, 1'b0);
		axi_wr(8'h00, 8'h0c, resp);
		for (k = 0; k < 3; k++)
			run_seq(8'h08, 8'h00, 1, 8'(1 << k), k > 0);
		run_seq(8'h08, 8'h40, 8, 8'hff, 1'b1);
		axi_wr(8'h00, 8'h08, resp);
		run_seq(8'h08, 8'h00, 1, 8'h01, 1'b0);
		for (k = 0; k < 3; k++) begin
			axi_wr(8'h00, hb[k], resp);
			clr(1'b0);
			axi_wr(8'h04, 8'h07, resp);
			repeat (100) @(negedge sys_clk);
			r0 = res_cnt;
			@(posedge sys_clk);
			debug_halt <= 1'b1;
			repeat (240) @(negedge sys_clk);
			t0 = tick_cnt;
			repeat (192) @(negedge sys_clk);
			cmp("halt_busy", 1, seq_busy);
			cmp("halt_ticks", et[k], tick_cnt - t0);
			cmp("halt_results", er[k], res_cnt - r0);
			@(posedge sys_clk);
			debug_halt <= 1'b0;
			wait_done;
			cmp("results", 4, res_cnt);
			cmp("valid_flags", 8'h0f, valid_flags);
		end
		finish_test;
	end
endmodule
`default_nettype wire
